// >>> eva_defines.svh
// constants of the exception vector assigner
`ifndef EVA_DEFINES_SVH
`define EVA_DEFINES_SVH
`define EVA_VEC_DIVIDE    8'h00
`define EVA_VEC_DEBUG     8'h01
`define EVA_VEC_DOUBLE    8'h08
`define EVA_VEC_BAD_TASK  8'h0A
`define EVA_VEC_STACK     8'h0C
`define EVA_VEC_PROTECT   8'h0D
`define EVA_VEC_PAGE      8'h0E
`define EVA_VEC_SECURITY  8'h1E
`define EVA_NUM_PREDEF    32
`endif

// >>> eva_divide_check.sv
// divide error detector: zero divisor or quotient overflow
module eva_divide_check
	import eva_pkg::*;
#(
	parameter int W = 64
) (
	input  wire logic         div_valid_i,
	input  wire logic         div_signed_i,
	input  wire logic [2*W-1:0] dividend_i,
	input  wire logic [W-1:0] divisor_i,
	output logic              div_error_o
);
	logic zero_div;
	logic ovf;
	logic [2*W-1:0] mag_n;
	logic [W-1:0]   mag_d;
	logic [2*W-1:0] lim;
	always_comb begin
		zero_div = (divisor_i == '0);
		mag_n = (div_signed_i && dividend_i[2*W-1]) ? (~dividend_i + 1'b1) : dividend_i;
		mag_d = (div_signed_i && divisor_i[W-1]) ? (~divisor_i + 1'b1) : divisor_i;
		// quotient bound: unsigned 2^W, signed 2^(W-1) (neg result may reach it exactly)
		lim = {{W{1'b0}}, mag_d} << (div_signed_i ? W - 1 : W);
		if (div_signed_i && (dividend_i[2*W-1] ^ divisor_i[W-1]))
			ovf = !zero_div && (mag_n > lim + {{W{1'b0}}, mag_d} - 1'b1);
		else
			ovf = !zero_div && (mag_n >= lim);
		div_error_o = div_valid_i && (zero_div || ovf);
	end
endmodule

// >>> eva_pipe_model.sv
// model of the execution pipeline and interrupt logic feeding the assigner
module eva_pipe_model #(
	parameter int W = 8
) (
	input  wire logic [9:0]     req_i,
	input  wire logic [2*W-1:0] dividend_i,
	input  wire logic [W-1:0]   divisor_i,
	output logic      [9:0]     line_o,
	output logic      [2*W-1:0] dividend_o,
	output logic      [W-1:0]   divisor_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// one level per source, held for the single cycle the bench asks for
	assign line_o = req_i;
	// operands are meaningless without a divide: show the inverse, not stale data
	assign dividend_o = req_i[1] ? dividend_i : ~dividend_i;
	assign divisor_o = req_i[1] ? divisor_i : ~divisor_i;
endmodule

// >>> eva_pkg.sv
// types of the exception vector assigner
package eva_pkg;
	typedef enum logic [1:0] {
		EVA_KIND_NONE  = 2'h0,
		EVA_KIND_FAULT = 2'h1,
		EVA_KIND_TRAP  = 2'h2,
		EVA_KIND_ABORT = 2'h3
	} eva_kind_t;
	typedef enum logic [1:0] {
		EVA_CLS_NONE    = 2'h0,
		EVA_CLS_BENIGN  = 2'h1,
		EVA_CLS_CONTRIB = 2'h2
	} eva_cls_t;
	typedef enum logic [2:0] {
		EVA_ST_IDLE = 3'b001,
		EVA_ST_BUSY = 3'b010,
		EVA_ST_HOLD = 3'b100
	} eva_state_t;
endpackage

// >>> eva_top.sv
// exception vector assigner top
`include "eva_defines.svh"
module eva_top
	import eva_pkg::*;
#(
	parameter int W = 64,
	parameter int AW = 64
) (
	input  wire logic          clock_i,
	input  wire logic          reset_i,
	input  wire logic          div_valid_i,
	input  wire logic          div_signed_i,
	input  wire logic [2*W-1:0] dividend_i,
	input  wire logic [W-1:0]  divisor_i,
	input  wire logic          debug_event_i,
	input  wire logic          debug_is_trap_i,
	input  wire logic          double_fault_event_i,
	input  wire logic          bad_task_segment_event_i,
	input  wire logic          stack_fault_event_i,
	input  wire logic          protection_violation_event_i,
	input  wire logic          page_fault_event_i,
	input  wire logic          paging_enabled_i,
	input  wire logic          security_event_i,
	input  wire logic          software_interrupt_instr_i,
	input  wire logic [7:0]    soft_vector_i,
	input  wire logic          maskable_external_request_i,
	input  wire logic [7:0]    ext_vector_i,
	input  wire logic [AW-1:0] instr_addr_i,
	input  wire logic [AW-1:0] next_addr_i,
	output logic               event_valid_o,
	output logic [7:0]         vector_o,
	output logic [1:0]         kind_o,
	output logic               precise_o,
	output logic [1:0]         class_o,
	output logic               error_code_o,
	output logic [AW-1:0]      saved_addr_o,
	output logic               commit_o,
	output logic               discard_o
);
	////////////////////////////////////////////////////////////////
	// divide error detection
	logic div_err;
	eva_divide_check #(.W(W)) u_div (
		.div_valid_i  (div_valid_i),
		.div_signed_i (div_signed_i),
		.dividend_i   (dividend_i),
		.divisor_i    (divisor_i),
		.div_error_o  (div_err)
	);
	////////////////////////////////////////////////////////////////
	// state
	typedef struct packed {
		logic          valid;
		logic [7:0]    vec;
		eva_kind_t     kind;
		logic          precise;
		eva_cls_t      cls;
		logic          ecode;
		logic [AW-1:0] addr;
		logic          commit;
		logic          discard;
	} eva_reg_t;
	eva_reg_t r;
	eva_reg_t next_r;

	function automatic logic is_reserved(input logic [7:0] v);
		is_reserved = (v == 8'h09) || (v == 8'h0F) || (v == 8'h1F) ||
			((v >= 8'h14) && (v <= 8'h1C));
	endfunction

	logic pf_ok;
	assign pf_ok = page_fault_event_i && paging_enabled_i;

	////////////////////////////////////////////////////////////////
	// priority select and classification, fixed low vectors except soft_vector_i and ext_vector_i
	always_comb begin
		next_r = '0;
		next_r.kind = EVA_KIND_NONE;
		next_r.cls = EVA_CLS_NONE;
		if (double_fault_event_i) begin
			next_r.valid = 1'b1;
			next_r.vec = `EVA_VEC_DOUBLE;
			next_r.kind = EVA_KIND_ABORT;
			next_r.precise = 1'b0;
			next_r.ecode = 1'b1;
		end else if (div_err) begin
			next_r.valid = 1'b1;
			next_r.vec = `EVA_VEC_DIVIDE;
			next_r.kind = EVA_KIND_FAULT;
			next_r.precise = 1'b1;
			next_r.cls = EVA_CLS_CONTRIB;
			next_r.ecode = 1'b0;
		end else if (debug_event_i) begin
			next_r.valid = 1'b1;
			next_r.vec = `EVA_VEC_DEBUG;
			next_r.kind = debug_is_trap_i ? EVA_KIND_TRAP : EVA_KIND_FAULT;
			next_r.precise = 1'b1;
			next_r.cls = EVA_CLS_BENIGN;
		end else if (bad_task_segment_event_i) begin
			next_r.valid = 1'b1;
			next_r.vec = `EVA_VEC_BAD_TASK;
			next_r.kind = EVA_KIND_FAULT;
			next_r.precise = 1'b1;
			next_r.cls = EVA_CLS_CONTRIB;
			next_r.ecode = 1'b1;
		end else if (stack_fault_event_i) begin
			next_r.valid = 1'b1;
			next_r.vec = `EVA_VEC_STACK;
			next_r.kind = EVA_KIND_FAULT;
			next_r.precise = 1'b1;
			next_r.cls = EVA_CLS_CONTRIB;
			next_r.ecode = 1'b1;
		end else if (protection_violation_event_i) begin
			next_r.valid = 1'b1;
			next_r.vec = `EVA_VEC_PROTECT;
			next_r.kind = EVA_KIND_FAULT;
			next_r.precise = 1'b1;
			next_r.cls = EVA_CLS_CONTRIB;
			next_r.ecode = 1'b1;
		end else if (pf_ok) begin
			next_r.valid = 1'b1;
			next_r.vec = `EVA_VEC_PAGE;
			next_r.kind = EVA_KIND_FAULT;
			next_r.precise = 1'b1;
			next_r.cls = EVA_CLS_CONTRIB;
			next_r.ecode = 1'b1;
		end else if (security_event_i) begin
			next_r.valid = 1'b1;
			next_r.vec = `EVA_VEC_SECURITY;
			next_r.kind = EVA_KIND_NONE;
			next_r.precise = 1'b1;
			next_r.cls = EVA_CLS_CONTRIB;
			next_r.ecode = 1'b1;
		end else if (software_interrupt_instr_i) begin
			next_r.valid = 1'b1;
			next_r.vec = soft_vector_i;
			next_r.kind = EVA_KIND_TRAP;
			next_r.precise = 1'b1;
			next_r.cls = EVA_CLS_BENIGN;
		end else if (maskable_external_request_i) begin
			next_r.valid = 1'b1;
			next_r.vec = ext_vector_i;
			next_r.kind = EVA_KIND_NONE;
			next_r.precise = 1'b0;
			next_r.cls = EVA_CLS_BENIGN;
		end
		// restart point and state handling
		if (next_r.valid) begin
			if (next_r.kind == EVA_KIND_FAULT) begin
				next_r.addr = instr_addr_i;
				next_r.discard = 1'b1;
			end else if (next_r.kind == EVA_KIND_TRAP) begin
				next_r.addr = next_addr_i;
				next_r.commit = 1'b1;
			end else if (next_r.kind == EVA_KIND_NONE) begin
				next_r.addr = (maskable_external_request_i && !security_event_i) ?
					next_addr_i : instr_addr_i;
				next_r.discard = security_event_i;
			end else begin
				next_r.addr = instr_addr_i;
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (reset_i)
			r <= '0;
		else
			r <= next_r;
	end

	////////////////////////////////////////////////////////////////
	// outputs
	assign event_valid_o = r.valid;
	assign vector_o      = r.vec;
	assign kind_o        = r.kind;
	assign precise_o     = r.precise;
	assign class_o       = r.cls;
	assign error_code_o  = r.ecode;
	assign saved_addr_o  = r.addr;
	assign commit_o      = r.commit;
	assign discard_o     = r.discard;

	////////////////////////////////////////////////////////////////
	// checks
	logic internal_src;
	assign internal_src = div_err || debug_event_i || double_fault_event_i ||
		bad_task_segment_event_i || stack_fault_event_i ||
		protection_violation_event_i || pf_ok || security_event_i;

	sequence s_div_seen;
		div_err && !double_fault_event_i;
	endsequence
	sequence s_div_out;
		event_valid_o && vector_o == 8'h00 && kind_o == EVA_KIND_FAULT && !error_code_o;
	endsequence

	chk_div_vector: assert property (@(posedge clock_i) disable iff (reset_i)
		s_div_seen |=> s_div_out)
		else $error("divide error not reported on vector 0");
	chk_div_restart: assert property (@(posedge clock_i) disable iff (reset_i)
		s_div_seen |=> saved_addr_o == $past(instr_addr_i) && discard_o)
		else $error("divide error restart address wrong");
	chk_div_zero: assert property (@(posedge clock_i) disable iff (reset_i)
		div_valid_i && divisor_i == '0 |-> div_err)
		else $error("zero divisor not detected");
	chk_double_abort: assert property (@(posedge clock_i) disable iff (reset_i)
		double_fault_event_i |=> vector_o == 8'h08 && kind_o == EVA_KIND_ABORT && !precise_o)
		else $error("double fault misclassified");
	chk_page_gate: assert property (@(posedge clock_i) disable iff (reset_i)
		event_valid_o && vector_o == 8'h0E |-> $past(paging_enabled_i))
		else $error("page fault without paging");
	chk_reserved_vec: assert property (@(posedge clock_i) disable iff (reset_i)
		$past(internal_src) && event_valid_o |-> !is_reserved(vector_o))
		else $error("reserved vector raised internally");
	chk_ext_plain: assert property (@(posedge clock_i) disable iff (reset_i)
		maskable_external_request_i && !internal_src && !software_interrupt_instr_i |=>
		vector_o == $past(ext_vector_i) && kind_o == EVA_KIND_NONE && !precise_o)
		else $error("external request misreported");
	chk_soft_any: assert property (@(posedge clock_i) disable iff (reset_i)
		software_interrupt_instr_i && !internal_src |=>
		vector_o == $past(soft_vector_i) && saved_addr_o == $past(next_addr_i) && commit_o)
		else $error("software interrupt misreported");
	chk_security: assert property (@(posedge clock_i) disable iff (reset_i)
		event_valid_o && vector_o == 8'h1E && !$past(maskable_external_request_i) &&
		!$past(software_interrupt_instr_i) |-> precise_o && class_o == EVA_CLS_CONTRIB)
		else $error("security event misclassified");

	////////////////////////////////////////////////////////////////
	// winning source per cycle, bit 0 is the highest priority
	logic [9:0] src;
	logic [9:0] win;
	assign src = {maskable_external_request_i, software_interrupt_instr_i, security_event_i,
		pf_ok, protection_violation_event_i, stack_fault_event_i,
		bad_task_segment_event_i, debug_event_i, div_err, double_fault_event_i};
	assign win = src & ~(src - 10'h001);

	chk_div_ovf: assert property (@(posedge clock_i) disable iff (reset_i)
		div_valid_i && divisor_i != '0 && win[1] |=>
		event_valid_o && vector_o == `EVA_VEC_DIVIDE)
		else $error("divide overflow not reported");

	chk_div_noecode: assert property (@(posedge clock_i) disable iff (reset_i)
		win[1] |=>
		!error_code_o && !commit_o)
		else $error("divide error pushed an error code");

	chk_div_precise: assert property (@(posedge clock_i) disable iff (reset_i)
		win[1] |=>
		precise_o && class_o == EVA_CLS_CONTRIB)
		else $error("divide error not precise");

	chk_debug_vec: assert property (@(posedge clock_i) disable iff (reset_i)
		win[2] |=>
		event_valid_o && vector_o == `EVA_VEC_DEBUG && precise_o)
		else $error("debug event not on vector 1");

	chk_debug_trap: assert property (@(posedge clock_i) disable iff (reset_i)
		win[2] && debug_is_trap_i |=> kind_o == EVA_KIND_TRAP && commit_o && !discard_o &&
		saved_addr_o == $past(next_addr_i))
		else $error("debug trap restart wrong");

	chk_debug_fault: assert property (@(posedge clock_i) disable iff (reset_i)
		win[2] && !debug_is_trap_i |=> kind_o == EVA_KIND_FAULT && discard_o && !commit_o &&
		saved_addr_o == $past(instr_addr_i))
		else $error("debug fault restart wrong");

	chk_task_vec: assert property (@(posedge clock_i) disable iff (reset_i)
		win[3] |=>
		event_valid_o && vector_o == `EVA_VEC_BAD_TASK && kind_o == EVA_KIND_FAULT)
		else $error("bad task segment vector wrong");

	chk_stack_vec: assert property (@(posedge clock_i) disable iff (reset_i)
		win[4] |=>
		event_valid_o && vector_o == `EVA_VEC_STACK && kind_o == EVA_KIND_FAULT)
		else $error("stack fault vector wrong");

	chk_prot_vec: assert property (@(posedge clock_i) disable iff (reset_i)
		win[5] |=>
		event_valid_o && vector_o == `EVA_VEC_PROTECT && kind_o == EVA_KIND_FAULT)
		else $error("protection violation vector wrong");

	chk_page_vec: assert property (@(posedge clock_i) disable iff (reset_i)
		win[6] |=>
		event_valid_o && vector_o == `EVA_VEC_PAGE && kind_o == EVA_KIND_FAULT)
		else $error("page fault vector wrong");

	chk_page_drop: assert property (@(posedge clock_i) disable iff (reset_i)
		page_fault_event_i && !paging_enabled_i && src == 10'h000 |=>
		!event_valid_o)
		else $error("page fault raised without paging");

	chk_sec_vec: assert property (@(posedge clock_i) disable iff (reset_i)
		win[7] |=>
		event_valid_o && vector_o == `EVA_VEC_SECURITY && class_o == EVA_CLS_CONTRIB)
		else $error("security event vector wrong");

	chk_soft_trap: assert property (@(posedge clock_i) disable iff (reset_i)
		win[8] |=>
		kind_o == EVA_KIND_TRAP && class_o == EVA_CLS_BENIGN)
		else $error("software interrupt not a benign trap");

	chk_soft_addr: assert property (@(posedge clock_i) disable iff (reset_i)
		win[8] |=> vector_o == $past(soft_vector_i) &&
		saved_addr_o == $past(next_addr_i) && commit_o && !discard_o)
		else $error("software interrupt restart wrong");

	chk_ext_class: assert property (@(posedge clock_i) disable iff (reset_i)
		win[9] |=> class_o == EVA_CLS_BENIGN && !commit_o && !discard_o &&
		saved_addr_o == $past(next_addr_i))
		else $error("external request attributes wrong");

	chk_abort_addr: assert property (@(posedge clock_i) disable iff (reset_i)
		win[0] |=>
		saved_addr_o == $past(instr_addr_i) && !commit_o && !discard_o)
		else $error("double fault restart wrong");

	chk_fault_drop: assert property (@(posedge clock_i) disable iff (reset_i)
		event_valid_o && kind_o == EVA_KIND_FAULT |->
		discard_o && !commit_o)
		else $error("fault kept instruction state");

	chk_trap_keep: assert property (@(posedge clock_i) disable iff (reset_i)
		event_valid_o && kind_o == EVA_KIND_TRAP |->
		commit_o && !discard_o)
		else $error("trap dropped instruction state");

	chk_predef_low: assert property (@(posedge clock_i) disable iff (reset_i)
		$past(internal_src) && event_valid_o |->
		vector_o[7:5] == 3'h0)
		else $error("internal event above predefined range");

	chk_idle_quiet: assert property (@(posedge clock_i) disable iff (reset_i)
		src == 10'h000 |=>
		!event_valid_o && !commit_o && !discard_o && !error_code_o)
		else $error("event reported with no source");

	chk_fault_ecode: assert property (@(posedge clock_i) disable iff (reset_i)
		win[3] || win[4] || win[5] || win[6] |=>
		error_code_o && precise_o)
		else $error("fault attributes wrong");
endmodule

// >>> tb_top.sv
// self-checking bench of the exception vector assigner
module tb_top;
	import eva_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int W = 8;
	localparam int AW = 16;
	typedef struct packed {
		logic [7:0]    vec;
		logic [1:0]    kind;
		logic          prec;
		logic [1:0]    cls;
		logic          ec;
		logic [AW-1:0] saved;
		logic          cm;
		logic          dc;
	} eva_exp_t;
	logic clock_i, reset_i, paging, dbg_trap, sgn;
	logic [9:0] req, line;
	logic [2*W-1:0] dividend, dvd_l;
	logic [W-1:0] divisor, dvs_l;
	logic [7:0] soft_v, ext_v, vector_o;
	logic [AW-1:0] ia, na, saved_addr_o;
	logic [1:0] kind_o, class_o;
	logic event_valid_o, precise_o, error_code_o, commit_o, discard_o;
	eva_exp_t got, exp_q[$], msk_q[$];
	logic [31:0] seed = 32'h0001_1A8B;
	int n_errors = 0, checks_done = 0, cycles = 0;
	assign got = {vector_o, kind_o, precise_o, class_o, error_code_o, saved_addr_o,
		commit_o, discard_o};
	////////////////////////////////////////////////////////////////////////////////
	eva_pipe_model #(.W(W)) PM (.req_i(req), .dividend_i(dividend), .divisor_i(divisor),
		.line_o(line), .dividend_o(dvd_l), .divisor_o(dvs_l));
	eva_top #(.W(W), .AW(AW)) DUT (.clock_i(clock_i), .reset_i(reset_i),
		.div_valid_i(line[1]), .div_signed_i(sgn), .dividend_i(dvd_l), .divisor_i(dvs_l),
		.debug_event_i(line[2]), .debug_is_trap_i(dbg_trap), .double_fault_event_i(line[0]),
		.bad_task_segment_event_i(line[3]), .stack_fault_event_i(line[4]),
		.protection_violation_event_i(line[5]), .page_fault_event_i(line[6]),
		.paging_enabled_i(paging), .security_event_i(line[7]),
		.software_interrupt_instr_i(line[8]), .soft_vector_i(soft_v),
		.maskable_external_request_i(line[9]), .ext_vector_i(ext_v),
		.instr_addr_i(ia), .next_addr_i(na), .event_valid_o(event_valid_o),
		.vector_o(vector_o), .kind_o(kind_o), .precise_o(precise_o), .class_o(class_o),
		.error_code_o(error_code_o), .saved_addr_o(saved_addr_o), .commit_o(commit_o),
		.discard_o(discard_o));
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		repeat (32) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction
	task automatic cmp_evt(input eva_exp_t g, input eva_exp_t e, input eva_exp_t m);
		checks_done++;
		if ((g & m) !== (e & m)) begin
			n_errors++;
			$display("BAD %0t got %h exp %h", $time, g & m, e & m);
		end
	endtask
	task automatic results();
		if (exp_q.size() != 0) begin
			n_errors++;
			$display("BAD %0t missing events %h exp %h", $time, 0, exp_q.size());
		end
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// drive one cycle of sources and note the winning event
	task automatic step(input logic [9:0] r);
		logic [31:0] a, b;
		eva_exp_t e, m;
		int sd, sv;
		logic ov, de;
		a = rnd();
		b = rnd();
		req = r;
		paging = a[31];
		dbg_trap = a[30];
		sgn = a[29];
		dividend = a[15:0];
		divisor = a[28] ? 8'h00 : b[7:0];
		soft_v = b[15:8];
		ext_v = b[23:16];
		ia = a[27:12];
		na = b[31:16];
		sd = $signed(dividend);
		sv = $signed(divisor);
		if (sgn)
			ov = divisor != 0 && (sd / sv > 127 || sd / sv < -128);
		else
			ov = dividend[15:8] >= divisor;
		de = r[1] && (divisor == 8'h00 || ov);
		e = '0;
		m = '1;
		if (r[0]) begin
			e.vec = 8'h08; e.kind = EVA_KIND_ABORT; e.saved = ia; m.cls = 0; m.ec = 0;
		end else if (de) begin
			e.kind = EVA_KIND_FAULT; e.prec = 1; e.cls = EVA_CLS_CONTRIB;
			e.saved = ia; e.dc = 1;
		end else if (r[2]) begin
			e.vec = 8'h01; e.prec = 1; e.cls = EVA_CLS_BENIGN; e.cm = dbg_trap;
			e.kind = dbg_trap ? EVA_KIND_TRAP : EVA_KIND_FAULT; e.dc = !dbg_trap;
			e.saved = dbg_trap ? na : ia;
		end else if (r[3] || r[4] || r[5] || (r[6] && paging)) begin
			e.vec = r[3] ? 8'h0A : r[4] ? 8'h0C : r[5] ? 8'h0D : 8'h0E;
			e.kind = EVA_KIND_FAULT; e.prec = 1; e.cls = EVA_CLS_CONTRIB;
			e.saved = ia; e.dc = 1; m.ec = 0; m.cls = {2{r[3] | r[4] | r[5]}};
		end else if (r[7]) begin
			e.vec = 8'h1E; e.prec = 1; e.cls = EVA_CLS_CONTRIB; e.ec = 1; e.dc = 1;
			m.saved = 0;
		end else if (r[8]) begin
			e.vec = soft_v; e.kind = EVA_KIND_TRAP; e.cls = EVA_CLS_BENIGN;
			e.saved = na; e.cm = 1; m.prec = 0; m.ec = 0;
		end else if (r[9]) begin
			e.vec = ext_v; e.saved = na; m.cls = 0; m.ec = 0;
		end
		if (r[0] || de || (r & 10'h3BC) != 0 || (r[6] && paging)) begin
			exp_q.push_back(e);
			msk_q.push_back(m);
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clock_i = 0;
		forever #5 clock_i = ~clock_i;
	end
	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 2000) begin
			n_errors++;
			results();
		end
	end
	// each reported event takes the oldest note; an event with none noted is wrong
	always @(posedge clock_i) begin
		#2;
		if (reset_i === 1'b0 && event_valid_o !== 1'b0) begin
			if (exp_q.size() == 0) begin
				n_errors++;
				$display("BAD %0t got %h exp %h", $time, got, 0);
			end else
				cmp_evt(got, exp_q.pop_front(), msk_q.pop_front());
		end
	end
	initial begin
		logic [31:0] x;
		reset_i = 1;
		req = 0; paging = 0; dbg_trap = 0; sgn = 0; dividend = 0; divisor = 0;
		soft_v = 0; ext_v = 0; ia = 0; na = 0;
		repeat (16) @(posedge clock_i);
		#1 reset_i = 0;
		for (int i = 0; i < 600; i++) begin
			@(posedge clock_i);
			#1;
			x = rnd();
			step(i < 40 ? 10'h001 << (i % 10) : x[9:0] & x[19:10] & x[29:20]);
		end
		@(posedge clock_i);
		#1 req = 0;
		repeat (3) @(posedge clock_i);
		#3 results();
	end
endmodule
